// ---- drive_mode_regs.vh ----
// Parameter codes, default values and timing figures of the drive mode block
`ifndef DRIVE_MODE_REGS_VH
`define DRIVE_MODE_REGS_VH

// ************************************************************
// Parameter codes
// ************************************************************
`define CODE_MASTER_SETPOINT_ONE 8'h01
`define CODE_MASTER_SETPOINT_TWO 8'h02
`define CODE_DIRECT_OUTPUT_PERCENT 8'h06
`define CODE_MASTER_UNIT_SPAN 8'h14
`define CODE_FEEDBACK_PULSES_PER_REV 8'h1F
`define CODE_FEEDBACK_MAX_SPEED 8'h22
`define CODE_OPEN_LOOP_SELECT 8'h3D
`define CODE_ANALOG_INPUT_ROLE 8'h54

// ************************************************************
// Default values
// ************************************************************
`define RST_MASTER_SETPOINT 16'h0000
`define RST_DIRECT_OUTPUT_PERCENT 16'h0000
`define RST_MASTER_UNIT_SPAN 16'h07D0
`define RST_FEEDBACK_PULSES_PER_REV 16'h003C
`define RST_FEEDBACK_MAX_SPEED 16'h07D0
`define RST_OPEN_LOOP_SELECT 16'h0000
`define RST_ANALOG_INPUT_ROLE 16'h0000

// ************************************************************
// Field values
// ************************************************************
`define OPEN_LOOP_ON 16'h0001
`define ROLE_ANALOG_FEEDBACK 16'h0002
`define PERCENT_FULL 16'h0064

// ************************************************************
// Timing
// ************************************************************
`define CLK_KHZ 40000
`define GATE_MS 100
`define GATE_CYCLES (`GATE_MS * `CLK_KHZ)
`define SECONDS_PER_MINUTE 60
`define GATES_PER_MINUTE (`SECONDS_PER_MINUTE * 1000 / `GATE_MS)
`define RAMP_MS 10
`define RAMP_CYCLES (`RAMP_MS * `CLK_KHZ)

`endif

// ---- drive_mode_setpoint_scaling.v ----
// Drive mode selection, master setpoint scaling and speed loop
`timescale 1ns/1ps
`include "drive_mode_regs.vh"

module drive_mode_setpoint_scaling #(
  parameter DRIVE_W = 12,
  parameter ADC_W = 12,
  parameter GATE_CYCLES = `GATE_CYCLES,
  parameter RAMP_CYCLES = `RAMP_CYCLES,
  parameter RAMP_STEP = 16,
  parameter LOOP_SHIFT = 2
) (
  // Clock and reset
  input wire sys_clk,
  input wire rst,
  // Keypad parameter port
  input wire [7:0] param_code,
  input wire [15:0] param_wdata,
  input wire param_wr,
  input wire param_rd,
  input wire keypad_locked,
  input wire restore_defaults,
  input wire tach_key,
  output reg [15:0] param_rdata,
  output reg param_rejected,
  output reg [15:0] tach_display,
  // Control pins
  input wire run_pin,
  input wire stop_pin,
  input wire setpoint_sel_pin,
  input wire fb_pulse_pin,
  // Analog input word from the on-chip converter
  input wire [ADC_W-1:0] analog_fb,
  // Drive and status
  output reg [DRIVE_W-1:0] drive_out,
  output reg running,
  output reg setpoint_two_active,
  output reg [15:0] target_rpm,
  output reg [15:0] feedback_rpm
);

  localparam [DRIVE_W-1:0] DRIVE_FULL = {DRIVE_W{1'b1}};
  localparam [ADC_W-1:0] ADC_FULL = {ADC_W{1'b1}};
  localparam ACC_W = DRIVE_W + 12;
  localparam [ACC_W-1:0] ACC_MAX = {1'b0, {(ACC_W-1){1'b1}}};
  localparam [31:0] GATES_PER_MIN = `GATES_PER_MINUTE;
  // a * b / c with a guard against a zero divisor
  function [31:0] scale;
    input [31:0] a;
    input [31:0] b;
    input [31:0] c;
    begin
      scale = (c == 32'h0) ? 32'h0 : (a * b) / c;
    end
  endfunction
  // Clamp a wide value into 16 bits
  function [15:0] sat16;
    input [31:0] v;
    begin
      sat16 = (v > 32'h0000FFFF) ? 16'hFFFF : v[15:0];
    end
  endfunction
  // ************************************************************
  // Parameter store
  // ************************************************************
  reg [15:0] master_setpoint_one_ff;
  reg [15:0] master_setpoint_two_ff;
  reg [15:0] direct_output_percent_ff;
  reg [15:0] master_unit_span_ff;
  reg [15:0] feedback_pulses_per_rev_ff;
  reg [15:0] feedback_max_speed_ff;
  reg [15:0] open_loop_select_ff;
  reg [15:0] analog_input_role_ff;
  // Writes land only while the keypad is unlocked
  wire wr_ok = param_wr & ~keypad_locked;
  // Reset and restore both load the factory set; restore wins over a write
  always @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      master_setpoint_one_ff <= `RST_MASTER_SETPOINT;
      master_setpoint_two_ff <= `RST_MASTER_SETPOINT;
      direct_output_percent_ff <= `RST_DIRECT_OUTPUT_PERCENT;
      master_unit_span_ff <= `RST_MASTER_UNIT_SPAN;
      feedback_pulses_per_rev_ff <= `RST_FEEDBACK_PULSES_PER_REV;
      feedback_max_speed_ff <= `RST_FEEDBACK_MAX_SPEED;
      open_loop_select_ff <= `RST_OPEN_LOOP_SELECT;
      analog_input_role_ff <= `RST_ANALOG_INPUT_ROLE;
    end else if (restore_defaults) begin
      master_setpoint_one_ff <= `RST_MASTER_SETPOINT;
      master_setpoint_two_ff <= `RST_MASTER_SETPOINT;
      direct_output_percent_ff <= `RST_DIRECT_OUTPUT_PERCENT;
      master_unit_span_ff <= `RST_MASTER_UNIT_SPAN;
      feedback_pulses_per_rev_ff <= `RST_FEEDBACK_PULSES_PER_REV;
      feedback_max_speed_ff <= `RST_FEEDBACK_MAX_SPEED;
      open_loop_select_ff <= `RST_OPEN_LOOP_SELECT;
      analog_input_role_ff <= `RST_ANALOG_INPUT_ROLE;
    end else if (wr_ok) begin
      case (param_code)
        `CODE_MASTER_SETPOINT_ONE: master_setpoint_one_ff <= param_wdata;
        `CODE_MASTER_SETPOINT_TWO: master_setpoint_two_ff <= param_wdata;
        `CODE_DIRECT_OUTPUT_PERCENT: direct_output_percent_ff <= param_wdata;
        `CODE_MASTER_UNIT_SPAN: master_unit_span_ff <= param_wdata;
        `CODE_FEEDBACK_PULSES_PER_REV: feedback_pulses_per_rev_ff <= param_wdata;
        `CODE_FEEDBACK_MAX_SPEED: feedback_max_speed_ff <= param_wdata;
        `CODE_OPEN_LOOP_SELECT: open_loop_select_ff <= param_wdata;
        `CODE_ANALOG_INPUT_ROLE: analog_input_role_ff <= param_wdata;
        default: ;
      endcase
    end
  end

  // ************************************************************
  // Parameter read-back
  // ************************************************************
  reg [15:0] rd_mux;
  // Reads are served whether locked or not; unknown codes read zero
  always @* begin
    case (param_code)
      `CODE_MASTER_SETPOINT_ONE: rd_mux = master_setpoint_one_ff;
      `CODE_MASTER_SETPOINT_TWO: rd_mux = master_setpoint_two_ff;
      `CODE_DIRECT_OUTPUT_PERCENT: rd_mux = direct_output_percent_ff;
      `CODE_MASTER_UNIT_SPAN: rd_mux = master_unit_span_ff;
      `CODE_FEEDBACK_PULSES_PER_REV: rd_mux = feedback_pulses_per_rev_ff;
      `CODE_FEEDBACK_MAX_SPEED: rd_mux = feedback_max_speed_ff;
      `CODE_OPEN_LOOP_SELECT: rd_mux = open_loop_select_ff;
      `CODE_ANALOG_INPUT_ROLE: rd_mux = analog_input_role_ff;
      default: rd_mux = 16'h0000;
    endcase
  end

  // Read data and the reject flag are one-cycle answers to a strobe
  always @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      param_rdata <= 16'h0000;
      param_rejected <= 1'b0;
    end else begin
      if (param_rd)
        param_rdata <= rd_mux;
      param_rejected <= param_wr & keypad_locked;
    end
  end

  // ************************************************************
  // Pin synchronisers and run state
  // ************************************************************
  reg [1:0] run_sync_ff;
  reg [1:0] stop_sync_ff;
  reg [1:0] sel_sync_ff;
  reg [1:0] pulse_sync_ff;
  reg pulse_last_ff;
  reg run_last_ff;

  // Two stages each; only the second stage, bit 1, is read by logic
  always @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      run_sync_ff <= 2'b00;
      stop_sync_ff <= 2'b00;
      sel_sync_ff <= 2'b00;
      pulse_sync_ff <= 2'b00;
      pulse_last_ff <= 1'b0;
      run_last_ff <= 1'b0;
    end else begin
      run_sync_ff <= {run_sync_ff[0], run_pin};
      stop_sync_ff <= {stop_sync_ff[0], stop_pin};
      sel_sync_ff <= {sel_sync_ff[0], setpoint_sel_pin};
      pulse_sync_ff <= {pulse_sync_ff[0], fb_pulse_pin};
      pulse_last_ff <= pulse_sync_ff[1];
      run_last_ff <= run_sync_ff[1];
    end
  end
  wire run_rise = run_sync_ff[1] & ~run_last_ff;
  wire pulse_rise = pulse_sync_ff[1] & ~pulse_last_ff;
  // Stop is a level and overrides a run edge, so the drive fails safe
  always @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      running <= 1'b0;
      setpoint_two_active <= 1'b0;
    end else begin
      if (stop_sync_ff[1])
        running <= 1'b0;
      else if (run_rise)
        running <= 1'b1;
      setpoint_two_active <= sel_sync_ff[1];
    end
  end

  // ************************************************************
  // Rate dividers
  // ************************************************************
  reg [31:0] gate_cnt_ff;
  reg [31:0] ramp_cnt_ff;
  reg gate_tick_ff;
  reg ramp_tick_ff;
  // Gate window for pulse counting and a faster ramp/loop tick
  always @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      gate_cnt_ff <= 32'h00000000;
      ramp_cnt_ff <= 32'h00000000;
      gate_tick_ff <= 1'b0;
      ramp_tick_ff <= 1'b0;
    end else begin
      gate_tick_ff <= (gate_cnt_ff == GATE_CYCLES - 1);
      ramp_tick_ff <= (ramp_cnt_ff == RAMP_CYCLES - 1);
      gate_cnt_ff <= (gate_cnt_ff == GATE_CYCLES - 1) ? 32'h00000000 : gate_cnt_ff + 32'h00000001;
      ramp_cnt_ff <= (ramp_cnt_ff == RAMP_CYCLES - 1) ? 32'h00000000 : ramp_cnt_ff + 32'h00000001;
    end
  end
  // ************************************************************
  // Frequency feedback measurement
  // ************************************************************
  reg [15:0] pulse_cnt_ff;

  // Pulses per gate, scaled to revolutions per minute by the tooth count;
  // an edge on the closing cycle starts the next window instead of being lost
  always @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      pulse_cnt_ff <= 16'h0000;
      feedback_rpm <= 16'h0000;
    end else if (gate_tick_ff) begin
      pulse_cnt_ff <= {15'h0000, pulse_rise};
      feedback_rpm <= sat16(scale({16'h0000, pulse_cnt_ff}, GATES_PER_MIN,
                            {16'h0000, feedback_pulses_per_rev_ff}));
    end else if (pulse_rise && pulse_cnt_ff != 16'hFFFF) begin
      pulse_cnt_ff <= pulse_cnt_ff + 16'h0001;
    end
  end

  // ************************************************************
  // Feedback in engineering units and target speed
  // ************************************************************
  wire analog_mode = (analog_input_role_ff == `ROLE_ANALOG_FEEDBACK);
  wire [15:0] active_sp = setpoint_two_active ? master_setpoint_two_ff
                                              : master_setpoint_one_ff;
  reg [15:0] fb_eu;

  // Analog path never looks at max speed or pulse count
  always @* begin
    if (analog_mode)
      fb_eu = sat16(scale({{(32-ADC_W){1'b0}}, analog_fb},
                          {16'h0000, master_unit_span_ff},
                          {{(32-ADC_W){1'b0}}, ADC_FULL}));
    else
      fb_eu = sat16(scale({16'h0000, feedback_rpm},
                          {16'h0000, master_unit_span_ff},
                          {16'h0000, feedback_max_speed_ff}));
  end

  // Target speed at the sensor and the tach display value
  always @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      target_rpm <= 16'h0000;
      tach_display <= 16'h0000;
    end else begin
      target_rpm <= sat16(scale({16'h0000, active_sp},
                                {16'h0000, feedback_max_speed_ff},
                                {16'h0000, master_unit_span_ff}));
      if (tach_key)
        tach_display <= fb_eu;
    end
  end

  // ************************************************************
  // Setpoint ramp
  // ************************************************************
  reg [15:0] ramp_sp_ff;

  // Ramped setpoint walks toward the active setpoint, restarting from zero
  always @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      ramp_sp_ff <= 16'h0000;
    end else if (!running) begin
      ramp_sp_ff <= 16'h0000;
    end else if (ramp_tick_ff) begin
      if (active_sp > ramp_sp_ff + RAMP_STEP)
        ramp_sp_ff <= ramp_sp_ff + RAMP_STEP[15:0];
      else if (active_sp + RAMP_STEP < ramp_sp_ff)
        ramp_sp_ff <= ramp_sp_ff - RAMP_STEP[15:0];
      else
        ramp_sp_ff <= active_sp;
    end
  end

  // ************************************************************
  // Speed loop and output selection
  // ************************************************************
  localparam ST_STOP = 3'b001;
  localparam ST_DIRECT = 3'b010;
  localparam ST_MASTER = 3'b100;

  wire direct_on = (open_loop_select_ff == `OPEN_LOOP_ON);
  wire signed [17:0] loop_err = $signed({2'b00, ramp_sp_ff}) - $signed({2'b00, fb_eu});
  wire signed [ACC_W-1:0] acc_step =
    $signed({{(ACC_W-18){loop_err[17]}}, loop_err}) >>> LOOP_SHIFT; // Re-signed: keeps sign
  reg signed [ACC_W-1:0] acc_ff;
  reg signed [ACC_W:0] acc_sum;
  reg [2:0] mode_ff;
  reg [15:0] pct_clip;
  reg [31:0] direct_level;
  // Integrating loop; clamped so a stalled motor cannot wind it up
  always @* begin
    acc_sum = {acc_ff[ACC_W-1], acc_ff} + {acc_step[ACC_W-1], acc_step};
    pct_clip = (direct_output_percent_ff > `PERCENT_FULL) ? `PERCENT_FULL
                                                          : direct_output_percent_ff;
    direct_level = scale({16'h0000, pct_clip}, {{(32-DRIVE_W){1'b0}}, DRIVE_FULL},
                         {16'h0000, `PERCENT_FULL});
  end
  // Drive state follows run and the direct select
  always @(posedge sys_clk or posedge rst) begin
    if (rst)
      mode_ff <= ST_STOP;
    else if (!running)
      mode_ff <= ST_STOP;
    else if (direct_on)
      mode_ff <= ST_DIRECT;
    else
      mode_ff <= ST_MASTER;
  end

  // Output register; direct bypasses ramp and loop entirely
  always @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      acc_ff <= {ACC_W{1'b0}};
      drive_out <= {DRIVE_W{1'b0}};
    end else begin
      case (mode_ff)
        ST_DIRECT: begin
          acc_ff <= {ACC_W{1'b0}};
          drive_out <= direct_level[DRIVE_W-1:0];
        end
        ST_MASTER: begin
          if (ramp_tick_ff) begin
            if (acc_sum[ACC_W])
              acc_ff <= {ACC_W{1'b0}};
            else if (acc_sum[ACC_W-1:0] > ACC_MAX)
              acc_ff <= ACC_MAX;
            else
              acc_ff <= acc_sum[ACC_W-1:0];
          end
          drive_out <= acc_ff[ACC_W-2 -: DRIVE_W];
        end
        default: begin
          acc_ff <= {ACC_W{1'b0}};
          drive_out <= {DRIVE_W{1'b0}};
        end
      endcase
    end
  end

endmodule // drive_mode_setpoint_scaling

// ---- drive_mode_partner.sv ----
// Model of the feedback side: pulse sensor on the shaft and analog tach
`timescale 1ns/1ps
module drive_mode_partner (
  // Clock
  input wire sys_clk,
  // Shaft speed and tach level chosen by the bench
  input wire [15:0] pulse_period,
  input wire [11:0] tach_level,
  // Sensor outputs
  output reg fb_pulse,
  output wire [11:0] analog_word
);
  integer phase_ff = 0;
  initial fb_pulse = 1'b0;
  // Exact period keeps the count per gate fixed; zero period is a stopped shaft
  always @(posedge sys_clk) begin
    if (pulse_period == 16'h0000) begin
      fb_pulse <= 1'b0;
      phase_ff <= 0;
    end else begin
      phase_ff <= (phase_ff + 1 >= pulse_period) ? 0 : phase_ff + 1;
      fb_pulse <= (phase_ff < pulse_period / 2);
    end
  end
  // Converter word, all ones stands for the full 10 V tach level
  assign analog_word = tach_level;
endmodule // drive_mode_partner

// ---- drive_mode_setpoint_scaling_props.sv ----
// Checker for the drive mode block, watching its ports only
`timescale 1ns/1ps
module drive_mode_checker #(
  parameter DRIVE_W = 12
) (
  // Clock and reset
  input wire sys_clk,
  input wire rst,
  // Keypad parameter port
  input wire [7:0] param_code,
  input wire [15:0] param_wdata,
  input wire param_wr,
  input wire param_rd,
  input wire keypad_locked,
  input wire restore_defaults,
  input wire tach_key,
  input wire [15:0] param_rdata,
  input wire param_rejected,
  input wire [15:0] tach_display,
  // Pins and drive
  input wire stop_pin,
  input wire setpoint_sel_pin,
  input wire [DRIVE_W-1:0] drive_out,
  input wire running,
  input wire setpoint_two_active
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);
  // Output path is two registers behind running, so check after five idle samples
  property p_idle_drive; !running [*5] |-> drive_out == 0; endproperty
  a_idle_drive: assert property (p_idle_drive) else $error("drive active while stopped");
  property p_stop_wins; stop_pin [*4] |-> !running; endproperty
  a_stop_wins: assert property (p_stop_wins) else $error("running despite stop");
  property p_sel_two; setpoint_sel_pin [*4] |-> setpoint_two_active; endproperty
  a_sel_two: assert property (p_sel_two) else $error("setpoint two not chosen");
  property p_sel_one; !setpoint_sel_pin [*4] |-> !setpoint_two_active; endproperty
  a_sel_one: assert property (p_sel_one) else $error("setpoint one not chosen");
  property p_reject; param_wr && keypad_locked |=> param_rejected; endproperty
  a_reject: assert property (p_reject) else $error("locked write not flagged");
  property p_no_reject; !(param_wr && keypad_locked) |=> !param_rejected; endproperty
  a_no_reject: assert property (p_no_reject) else $error("spurious reject");
  property p_rdata_hold; !param_rd |=> $stable(param_rdata); endproperty
  a_rdata_hold: assert property (p_rdata_hold) else $error("read data moved");
  property p_wr_rd;
    (param_wr && !keypad_locked && !restore_defaults && param_code == 8'h01) ##1
    (!param_wr && !restore_defaults) ##1
    (param_rd && !param_wr && !restore_defaults && param_code == 8'h01)
    |=> param_rdata == $past(param_wdata, 3);
  endproperty
  a_wr_rd: assert property (p_wr_rd) else $error("setpoint readback wrong");
  property p_restore_span;
    restore_defaults ##1 (param_rd && param_code == 8'h14) |=> param_rdata == 16'h07D0;
  endproperty
  a_restore_span: assert property (p_restore_span) else $error("span default wrong");
  property p_tach_hold; !tach_key |=> $stable(tach_display); endproperty
  a_tach_hold: assert property (p_tach_hold) else $error("tach display moved");
endmodule // drive_mode_checker

bind drive_mode_setpoint_scaling drive_mode_checker #(.DRIVE_W(DRIVE_W)) u_chk (
  .sys_clk(sys_clk), .rst(rst), .param_code(param_code), .param_wdata(param_wdata),
  .param_wr(param_wr), .param_rd(param_rd), .keypad_locked(keypad_locked),
  .restore_defaults(restore_defaults), .tach_key(tach_key), .param_rdata(param_rdata),
  .param_rejected(param_rejected), .tach_display(tach_display), .stop_pin(stop_pin),
  .setpoint_sel_pin(setpoint_sel_pin), .drive_out(drive_out), .running(running),
  .setpoint_two_active(setpoint_two_active));

// ---- test_drive_mode_setpoint_scaling.sv ----
// Self-checking bench for the drive mode and setpoint scaling block
`timescale 1ns/1ps
`include "drive_mode_regs.vh"
module test_drive_mode_setpoint_scaling;
  reg sys_clk = 1'b0, rst = 1'b1, param_wr = 1'b0, param_rd = 1'b0, keypad_locked = 1'b0;
  reg restore_defaults = 1'b0, tach_key = 1'b0, run_pin = 1'b0, stop_pin = 1'b0;
  reg setpoint_sel_pin = 1'b0;
  reg [7:0] param_code = 8'h00;
  reg [15:0] param_wdata = 16'h0000, pulse_period = 16'h000A;
  reg [11:0] tach_level = 12'h000;
  wire [15:0] param_rdata, tach_display, target_rpm, feedback_rpm;
  wire param_rejected, running, setpoint_two_active, fb_pulse_pin;
  wire [11:0] drive_out, analog_fb;
  integer bad_count = 0, check_count = 0;

  // Short gate and ramp periods keep the run brief
  drive_mode_setpoint_scaling #(.GATE_CYCLES(200), .RAMP_CYCLES(20)) u_dut (
    .sys_clk(sys_clk), .rst(rst), .param_code(param_code), .param_wdata(param_wdata),
    .param_wr(param_wr), .param_rd(param_rd), .keypad_locked(keypad_locked),
    .restore_defaults(restore_defaults), .tach_key(tach_key), .param_rdata(param_rdata),
    .param_rejected(param_rejected), .tach_display(tach_display), .run_pin(run_pin),
    .stop_pin(stop_pin), .setpoint_sel_pin(setpoint_sel_pin), .fb_pulse_pin(fb_pulse_pin),
    .analog_fb(analog_fb), .drive_out(drive_out), .running(running),
    .setpoint_two_active(setpoint_two_active), .target_rpm(target_rpm),
    .feedback_rpm(feedback_rpm));
  drive_mode_partner u_partner (.sys_clk(sys_clk), .pulse_period(pulse_period),
    .tach_level(tach_level), .fb_pulse(fb_pulse_pin), .analog_word(analog_fb));

  // Clock at 40 MHz
  initial begin
    forever #12.5 sys_clk = ~sys_clk;
  end

  task check(input [15:0] got, input [15:0] exp);
    begin
      check_count = check_count + 1;
      if (got !== exp) begin
        bad_count = bad_count + 1;
        $display("wrong value at %0t ns: seen %h expected %h", $time, got, exp);
      end
    end
  endtask
  task cyc(input integer n);
    repeat (n) @(negedge sys_clk);
  endtask
  // Tasks start and end on a falling edge; a write leaves one idle edge behind it
  task wr(input [7:0] c, input [15:0] d);
    begin
      param_code = c;
      param_wdata = d;
      param_wr = 1'b1;
      cyc(1);
      param_wr = 1'b0;
      cyc(1);
    end
  endtask
  task rd(input [7:0] c, input [15:0] e);
    begin
      param_code = c;
      param_rd = 1'b1;
      cyc(1);
      param_rd = 1'b0;
      cyc(1);
      check(param_rdata, e);
    end
  endtask
  task pulse_restore;
    begin
      restore_defaults = 1'b1;
      cyc(1);
      restore_defaults = 1'b0;
    end
  endtask
  task tach(input [15:0] e);
    begin
      tach_key = 1'b1;
      cyc(1);
      tach_key = 1'b0;
      cyc(2);
      check(tach_display, e);
    end
  endtask
  task run_pulse;
    begin
      run_pin = 1'b1;
      cyc(6);
      run_pin = 1'b0;
    end
  endtask

  // Factory values, span read first so it follows the restore directly
  task t_defaults;
    begin
      rd(`CODE_MASTER_UNIT_SPAN, `RST_MASTER_UNIT_SPAN);
      rd(`CODE_DIRECT_OUTPUT_PERCENT, `RST_DIRECT_OUTPUT_PERCENT);
      rd(`CODE_OPEN_LOOP_SELECT, `RST_OPEN_LOOP_SELECT);
      rd(`CODE_MASTER_SETPOINT_ONE, `RST_MASTER_SETPOINT);
      rd(`CODE_MASTER_SETPOINT_TWO, `RST_MASTER_SETPOINT);
      rd(`CODE_FEEDBACK_PULSES_PER_REV, `RST_FEEDBACK_PULSES_PER_REV);
      rd(`CODE_FEEDBACK_MAX_SPEED, `RST_FEEDBACK_MAX_SPEED);
      rd(`CODE_ANALOG_INPUT_ROLE, `RST_ANALOG_INPUT_ROLE);
      rd(8'h00, 16'h0000);
    end
  endtask
  task t_restore;
    begin
      wr(`CODE_MASTER_SETPOINT_ONE, 16'h1234);
      rd(`CODE_MASTER_SETPOINT_ONE, 16'h1234);
      wr(`CODE_MASTER_UNIT_SPAN, 16'h0055);
      wr(`CODE_OPEN_LOOP_SELECT, `OPEN_LOOP_ON);
      rd(`CODE_OPEN_LOOP_SELECT, 16'h0001);
      pulse_restore;
      t_defaults;
    end
  endtask
  // A locked keypad refuses the write but still answers reads
  task t_lock;
    begin
      keypad_locked = 1'b1;
      param_code = `CODE_DIRECT_OUTPUT_PERCENT;
      param_wdata = 16'h004D;
      param_wr = 1'b1;
      cyc(1);
      param_wr = 1'b0;
      check({15'h0000, param_rejected}, 16'h0001);
      cyc(1);
      check({15'h0000, param_rejected}, 16'h0000);
      rd(`CODE_DIRECT_OUTPUT_PERCENT, 16'h0000);
      keypad_locked = 1'b0;
    end
  endtask
  task t_direct;
    begin
      wr(`CODE_DIRECT_OUTPUT_PERCENT, 16'h0032);
      wr(`CODE_OPEN_LOOP_SELECT, `OPEN_LOOP_ON);
      run_pulse;
      check({15'h0000, running}, 16'h0001);
      check({4'h0, drive_out}, 16'h07FF);
      wr(`CODE_DIRECT_OUTPUT_PERCENT, 16'h0096);
      cyc(4);
      check({4'h0, drive_out}, 16'h0FFF);
      wr(`CODE_OPEN_LOOP_SELECT, 16'h0000);
      cyc(8);
      check({4'h0, drive_out}, 16'h0000);
      stop_pin = 1'b1;
      cyc(6);
      check({4'h0, drive_out}, 16'h0000);
      run_pulse;
      check({15'h0000, running}, 16'h0000);
      stop_pin = 1'b0;
    end
  endtask
  task t_scaling;
    begin
      wr(`CODE_MASTER_SETPOINT_ONE, 16'h03E8);
      wr(`CODE_MASTER_SETPOINT_TWO, 16'h01F4);
      cyc(6);
      check(target_rpm, 16'h03E8);
      setpoint_sel_pin = 1'b1;
      cyc(6);
      check(target_rpm, 16'h01F4);
      check({15'h0000, setpoint_two_active}, 16'h0001);
      setpoint_sel_pin = 1'b0;
      wr(`CODE_FEEDBACK_MAX_SPEED, 16'h06BD);
      wr(`CODE_MASTER_UNIT_SPAN, 16'h000F);
      wr(`CODE_MASTER_SETPOINT_ONE, 16'h000A);
      cyc(6);
      check(target_rpm, 16'h047E);
      pulse_restore;
      cyc(700);
      check(feedback_rpm, 16'h00C8);
      tach(16'h00C8);
      wr(`CODE_FEEDBACK_PULSES_PER_REV, 16'h001E);
      cyc(700);
      check(feedback_rpm, 16'h0190);
    end
  endtask
  task t_analog;
    begin
      pulse_restore;
      wr(`CODE_ANALOG_INPUT_ROLE, `ROLE_ANALOG_FEEDBACK);
      tach_level = 12'hFFF;
      cyc(4);
      tach(16'h07D0);
      wr(`CODE_FEEDBACK_MAX_SPEED, 16'h0063);
      wr(`CODE_FEEDBACK_PULSES_PER_REV, 16'h0007);
      tach_level = 12'h800;
      cyc(4);
      tach(16'h03E8);
    end
  endtask
  // Stopped shaft and a large setpoint: the ramp must build output slowly
  task t_loop;
    begin
      pulse_restore;
      pulse_period = 16'h0000;
      wr(`CODE_MASTER_SETPOINT_ONE, 16'h03E8);
      run_pulse;
      cyc(4);
      check({4'h0, drive_out}, 16'h0000);
      cyc(1200);
      check({15'h0000, drive_out != 12'h000}, 16'h0001);
      stop_pin = 1'b1;
      cyc(8);
      check({4'h0, drive_out}, 16'h0000);
      stop_pin = 1'b0;
    end
  endtask

  task complete_run;
    begin
      $display("checks %0d mismatches %0d", check_count, bad_count);
      if (bad_count == 0 && check_count > 0)
        $display("Result: passed");
      else
        $display("Result: failed");
      $finish;
    end
  endtask

  // Main sequence, reset held for three cycles
  initial begin
    cyc(3);
    rst = 1'b0;
    cyc(1);
    t_defaults;
    t_restore;
    t_lock;
    t_direct;
    t_scaling;
    t_analog;
    t_loop;
    complete_run;
  end
  // Watchdog well beyond the few thousand cycles the tests need
  initial begin
    repeat (20000) @(posedge sys_clk);
    bad_count = bad_count + 1;
    complete_run;
  end
endmodule // test_drive_mode_setpoint_scaling
